// file: logic/cirq_clock_sys_irq.sv
// clock group and system group interrupt status, masks and first-level requests
// assumes source flags come from other domains; apb master on core_clk
//
// What this block does
// (RULE_01) clock group request uses exactly three sources
// (RULE_02) system group request uses exactly four sources
// (RULE_03) periodic bit7, rollover bit6, alarm bit5
// (RULE_04) clock masks at bits 7:5, first mask
// (RULE_05) system status/masks at bits 3:0
// (RULE_06) supply below shutdown threshold sets bit3
// (RULE_07) die above 115 C sets bit2
// (RULE_08) die above 140 C sets bit1
// (RULE_09) watchdog timeout sets bit0
// (RULE_10) rising edge sets, host read clears
// (RULE_11) mask zero passes, mask one blocks
// (RULE_12) clock masks act on same-position bits
// (RULE_13) system masks act on same-position bits
// (RULE_14) all masks zero after reset
// (RULE_15) request high while set unmasked bit exists
// (RULE_16) host reads status after request to clear
//
// Register access over APB was decided locally.
module cirq_clock_sys_irq
   import cirq_pkg::*;
(
   input  wire logic               core_clk,
   input  wire logic               reset,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [ADDR_W-1:0]  paddr,
   input  wire logic [DATA_W-1:0]  pwdata,
   output logic      [DATA_W-1:0]  prdata,
   output logic                    pready,
   output logic                    pslverr,
   input  wire cirq_clock_src_type clockSrc,
   input  wire cirq_sys_src_type   sysSrc,
   output logic                    clockGroupIrq,
   output logic                    systemGroupIrq,
   output logic                    irqOut
);

   // ************************************************************
   // declarations
   // ************************************************************
   cirq_clock_src_type clockMeta_ff;
   cirq_clock_src_type clockSync_ff;
   cirq_clock_src_type clockLast_ff;
   cirq_sys_src_type   sysMeta_ff;
   cirq_sys_src_type   sysSync_ff;
   cirq_sys_src_type   sysLast_ff;

   logic [REG_W-1:0]  clockRise;
   logic [REG_W-1:0]  sysRise;
   logic [REG_W-1:0]  firstStatus_ff;
   logic [REG_W-1:0]  secondStatus_ff;
   logic [REG_W-1:0]  firstMask_ff;
   logic [REG_W-1:0]  secondMask_ff;
   logic [REG_W-1:0]  firstClear;
   logic [REG_W-1:0]  secondClear;
   logic [EVT_W-1:0]  evtStatus_ff;
   logic [EVT_W-1:0]  evtEnable_ff;
   logic [EVT_W-1:0]  evtSet;
   logic [EVT_W-1:0]  evtClear;
   logic              clockIrqLast_ff;
   logic              sysIrqLast_ff;
   logic [DATA_W-1:0] prdata_ff;
   logic [DATA_W-1:0] nxt_prdata;
   logic              setupPhase;
   logic              accessDone;
   logic              readDone;
   logic              writeDone;
   logic              mapped;

   function automatic logic addrHit(input logic [ADDR_W-1:0] addr,
                                    input logic [ADDR_W-1:0] idx);
      return addr == cirq_byte_addr(idx);
   endfunction

   // ************************************************************
   // source synchronisers and edge detect
   // ************************************************************
   always_ff @(posedge core_clk) begin
      if (reset) begin
         clockMeta_ff <= CLOCK_SRC_RESET;
         clockSync_ff <= CLOCK_SRC_RESET;
         clockLast_ff <= CLOCK_SRC_RESET;
      end else begin
         clockMeta_ff <= clockSrc;
         clockSync_ff <= clockMeta_ff;
         clockLast_ff <= clockSync_ff;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         sysMeta_ff <= SYS_SRC_RESET;
         sysSync_ff <= SYS_SRC_RESET;
         sysLast_ff <= SYS_SRC_RESET;
      end else begin
         sysMeta_ff <= sysSrc;
         sysSync_ff <= sysMeta_ff;
         sysLast_ff <= sysSync_ff;
      end
   end

   // last starts low, so a source already high at release reads as an edge
   // and sets its bit once; software must expect that first event
   always_comb begin
      clockRise = '0;
      sysRise   = '0;
      // (RULE_03) clock bit placement
      clockRise[PERIODIC_BIT] = clockSync_ff.periodicEventFlag
                                & ~clockLast_ff.periodicEventFlag;
      clockRise[SECOND_BIT]   = clockSync_ff.secondRolloverFlag
                                & ~clockLast_ff.secondRolloverFlag;
      clockRise[ALARM_BIT]    = clockSync_ff.alarmFlag & ~clockLast_ff.alarmFlag;
      // (RULE_06) supply low edge
      sysRise[SUPPLY_LOW_BIT] = sysSync_ff.supplyLowFlag & ~sysLast_ff.supplyLowFlag;
      // (RULE_07) die warm edge
      sysRise[DIE_WARM_BIT]   = sysSync_ff.dieWarmFlag & ~sysLast_ff.dieWarmFlag;
      // (RULE_08) die hot edge
      sysRise[DIE_HOT_BIT]    = sysSync_ff.dieHotFlag & ~sysLast_ff.dieHotFlag;
      // (RULE_09) watchdog edge
      sysRise[WATCHDOG_BIT]   = sysSync_ff.watchdogExpiryFlag
                                & ~sysLast_ff.watchdogExpiryFlag;
   end

   // ************************************************************
   // apb decode
   // ************************************************************
   assign setupPhase = psel & ~penable;
   assign accessDone = psel & penable;
   assign readDone   = accessDone & ~pwrite;
   assign writeDone  = accessDone & pwrite;
   assign pready     = 1'b1;
   assign prdata     = prdata_ff;

   always_comb begin
      mapped = addrHit(paddr, FIRST_STATUS_IDX) | addrHit(paddr, SECOND_STATUS_IDX)
             | addrHit(paddr, FIRST_MASK_IDX) | addrHit(paddr, SECOND_MASK_IDX)
             | addrHit(paddr, EVT_STATUS_IDX) | addrHit(paddr, EVT_CLEAR_IDX)
             | addrHit(paddr, EVT_ENABLE_IDX);
   end

   assign pslverr = accessDone & ~mapped;

   // read data is caught in the setup cycle so prdata comes from a flop
   always_comb begin
      nxt_prdata = '0;
      if (addrHit(paddr, FIRST_STATUS_IDX)) begin
         nxt_prdata[REG_W-1:0] = firstStatus_ff;
      end else if (addrHit(paddr, SECOND_STATUS_IDX)) begin
         nxt_prdata[REG_W-1:0] = secondStatus_ff;
      end else if (addrHit(paddr, FIRST_MASK_IDX)) begin
         nxt_prdata[REG_W-1:0] = firstMask_ff;
      end else if (addrHit(paddr, SECOND_MASK_IDX)) begin
         nxt_prdata[REG_W-1:0] = secondMask_ff;
      end else if (addrHit(paddr, EVT_STATUS_IDX)) begin
         nxt_prdata[EVT_W-1:0] = evtStatus_ff;
      end else if (addrHit(paddr, EVT_ENABLE_IDX)) begin
         nxt_prdata[EVT_W-1:0] = evtEnable_ff;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         prdata_ff <= '0;
      end else if (setupPhase & ~pwrite) begin
         prdata_ff <= nxt_prdata;
      end
   end

   // ************************************************************
   // status registers
   // ************************************************************
   // only bits that were shown to the host are cleared, so an edge landing
   // between capture and the access edge stays pending
   always_comb begin
      firstClear  = '0;
      secondClear = '0;
      // (RULE_10) clear on read
      if (readDone & addrHit(paddr, FIRST_STATUS_IDX)) begin
         firstClear = prdata_ff[REG_W-1:0];
      end
      if (readDone & addrHit(paddr, SECOND_STATUS_IDX)) begin
         secondClear = prdata_ff[REG_W-1:0];
      end
   end

   // (RULE_10) set wins over clear
   always_ff @(posedge core_clk) begin
      if (reset) begin
         firstStatus_ff <= STAT_RESET;
      end else begin
         firstStatus_ff <= ((firstStatus_ff & ~firstClear) | clockRise) & CLOCK_FIELD;
      end
   end

   // (RULE_05) system status field
   always_ff @(posedge core_clk) begin
      if (reset) begin
         secondStatus_ff <= STAT_RESET;
      end else begin
         secondStatus_ff <= ((secondStatus_ff & ~secondClear) | sysRise) & SYS_FIELD;
      end
   end

   // ************************************************************
   // mask registers
   // ************************************************************
   // (RULE_04) clock masks
   always_ff @(posedge core_clk) begin
      if (reset) begin
         // (RULE_14) unmasked
         firstMask_ff <= MASK_RESET;
      end else if (writeDone & addrHit(paddr, FIRST_MASK_IDX)) begin
         firstMask_ff <= pwdata[REG_W-1:0] & CLOCK_FIELD;
      end
   end

   // (RULE_05) system masks
   always_ff @(posedge core_clk) begin
      if (reset) begin
         // (RULE_14) unmasked
         secondMask_ff <= MASK_RESET;
      end else if (writeDone & addrHit(paddr, SECOND_MASK_IDX)) begin
         secondMask_ff <= pwdata[REG_W-1:0] & SYS_FIELD;
      end
   end

   // ************************************************************
   // first-level requests
   // ************************************************************
   // (RULE_01) three clock sources
   // (RULE_12) same-position clock mask
   // (RULE_11) mask one blocks
   // (RULE_15) level while unmasked set
   assign clockGroupIrq  = |(firstStatus_ff & ~firstMask_ff & CLOCK_FIELD);
   // (RULE_02) four system sources
   // (RULE_13) same-position system mask
   // (RULE_11) mask one blocks
   // (RULE_15) level while unmasked set
   assign systemGroupIrq = |(secondStatus_ff & ~secondMask_ff & SYS_FIELD);

   // ************************************************************
   // summary interrupt
   // ************************************************************
   always_ff @(posedge core_clk) begin
      if (reset) begin
         clockIrqLast_ff <= 1'b0;
         sysIrqLast_ff   <= 1'b0;
      end else begin
         clockIrqLast_ff <= clockGroupIrq;
         sysIrqLast_ff   <= systemGroupIrq;
      end
   end

   always_comb begin
      evtSet                = '0;
      evtSet[EVT_CLOCK_BIT] = clockGroupIrq & ~clockIrqLast_ff;
      evtSet[EVT_SYS_BIT]   = systemGroupIrq & ~sysIrqLast_ff;
      evtClear              = '0;
      if (writeDone & addrHit(paddr, EVT_CLEAR_IDX)) begin
         evtClear = pwdata[EVT_W-1:0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         evtStatus_ff <= EVT_RESET;
      end else begin
         evtStatus_ff <= (evtStatus_ff & ~evtClear) | evtSet;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         evtEnable_ff <= EVT_RESET;
      end else if (writeDone & addrHit(paddr, EVT_ENABLE_IDX)) begin
         evtEnable_ff <= pwdata[EVT_W-1:0];
      end
   end

   // (RULE_15) level while enabled event set
   assign irqOut = |(evtStatus_ff & evtEnable_ff);

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   sequence readFirstSeq;
      setupPhase & ~pwrite & addrHit(paddr, FIRST_STATUS_IDX) ##1 readDone;
   endsequence

   sequence readSecondSeq;
      setupPhase & ~pwrite & addrHit(paddr, SECOND_STATUS_IDX) ##1 readDone;
   endsequence

   property setOnRise(logic rise, logic flag);
      rise |=> flag;
   endproperty

   periodic_set_a:    assert property (setOnRise(clockRise[PERIODIC_BIT], // RULE_03
                         firstStatus_ff[PERIODIC_BIT])) else $error("periodic bit not set");
   rollover_set_a:    assert property (setOnRise(clockRise[SECOND_BIT], // RULE_03
                         firstStatus_ff[SECOND_BIT])) else $error("rollover bit not set");
   alarm_set_a:       assert property (setOnRise(clockRise[ALARM_BIT], // RULE_03
                         firstStatus_ff[ALARM_BIT])) else $error("alarm bit not set");
   supply_low_set_a:  assert property (setOnRise(sysRise[SUPPLY_LOW_BIT], // RULE_06
                         secondStatus_ff[SUPPLY_LOW_BIT])) else $error("supply bit not set");
   die_warm_set_a:    assert property (setOnRise(sysRise[DIE_WARM_BIT], // RULE_07
                         secondStatus_ff[DIE_WARM_BIT])) else $error("warm bit not set");
   die_hot_set_a:     assert property (setOnRise(sysRise[DIE_HOT_BIT], // RULE_08
                         secondStatus_ff[DIE_HOT_BIT])) else $error("hot bit not set");
   watchdog_set_a:    assert property (setOnRise(sysRise[WATCHDOG_BIT], // RULE_09
                         secondStatus_ff[WATCHDOG_BIT])) else $error("watchdog bit not set");

   first_read_clear_a: assert property ( // RULE_10
      (readFirstSeq ##0 (clockRise == '0)) |=> ((firstStatus_ff & $past(prdata_ff[REG_W-1:0]))
                                                == '0))
      else $error("first status not cleared by read");

   second_read_clear_a: assert property ( // RULE_10
      (readSecondSeq ##0 (sysRise == '0)) |=> ((secondStatus_ff & $past(prdata_ff[REG_W-1:0]))
                                               == '0))
      else $error("second status not cleared by read");

   clock_field_only_a: assert property ((firstStatus_ff & ~CLOCK_FIELD) == '0) // RULE_01
      else $error("stray first status bit");

   sys_field_only_a:  assert property ((secondStatus_ff & ~SYS_FIELD) == '0) // RULE_02
      else $error("stray second status bit");

   mask_reset_a:      assert property ($fell(reset) |-> // RULE_14
                         (firstMask_ff == MASK_RESET) && (secondMask_ff == MASK_RESET))
      else $error("mask not zero after reset");

   clock_mask_write_a: assert property ( // RULE_04
      writeDone & addrHit(paddr, FIRST_MASK_IDX) |=>
         firstMask_ff == ($past(pwdata[REG_W-1:0]) & CLOCK_FIELD))
      else $error("clock mask write lost");

   masked_quiet_a:    assert property ( // RULE_11
      (firstMask_ff == CLOCK_FIELD) |-> !clockGroupIrq)
      else $error("masked clock request raised");

   sys_irq_level_a:   assert property ( // RULE_15
      ((secondStatus_ff & ~secondMask_ff & SYS_FIELD) != '0) |-> systemGroupIrq)
      else $error("system request missing");

   sys_mask_write_a:  assert property ( // RULE_05
      writeDone & addrHit(paddr, SECOND_MASK_IDX) |=>
         secondMask_ff == ($past(pwdata[REG_W-1:0]) & SYS_FIELD))
      else $error("system mask write lost");

   sys_masked_quiet_a: assert property ( // RULE_11
      (secondMask_ff == SYS_FIELD) |-> !systemGroupIrq)
      else $error("masked system request raised");

   clock_irq_level_a: assert property ( // RULE_15
      ((firstStatus_ff & ~firstMask_ff & CLOCK_FIELD) != '0) |-> clockGroupIrq)
      else $error("clock request missing");

   status_hold_a:     assert property ( // RULE_10
      !readDone |=> (firstStatus_ff & $past(firstStatus_ff)) == $past(firstStatus_ff))
      else $error("first status lost without read");

   evt_set_wins_a:    assert property ( // RULE_15
      (evtSet != '0) |=> ((evtStatus_ff & $past(evtSet)) == $past(evtSet)))
      else $error("summary event lost");

endmodule // cirq_clock_sys_irq

// file: logic/cirq_pkg.sv
// constants, field layouts and carrier types of the clock and system interrupt groups
// assumes a 32-bit apb with byte addresses, register index times four
package cirq_pkg;

   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned REG_W  = 16;
   localparam int unsigned EVT_W  = 2;

   // register indexes; byte address is four times the index
   localparam logic [ADDR_W-1:0] FIRST_STATUS_IDX  = 8'h19;
   localparam logic [ADDR_W-1:0] SECOND_STATUS_IDX = 8'h1a;
   localparam logic [ADDR_W-1:0] FIRST_MASK_IDX    = 8'h21;
   localparam logic [ADDR_W-1:0] SECOND_MASK_IDX   = 8'h22;
   localparam logic [ADDR_W-1:0] EVT_STATUS_IDX    = 8'h00;
   localparam logic [ADDR_W-1:0] EVT_CLEAR_IDX     = 8'h01;
   localparam logic [ADDR_W-1:0] EVT_ENABLE_IDX    = 8'h02;
   localparam int unsigned       IDX_SHIFT         = 2;

   // clock group bit positions in the first status and mask registers
   localparam int unsigned PERIODIC_BIT = 7;
   localparam int unsigned SECOND_BIT   = 6;
   localparam int unsigned ALARM_BIT    = 5;
   // system group bit positions in the second status and mask registers
   localparam int unsigned SUPPLY_LOW_BIT = 3;
   localparam int unsigned DIE_WARM_BIT   = 2;
   localparam int unsigned DIE_HOT_BIT    = 1;
   localparam int unsigned WATCHDOG_BIT   = 0;

   localparam logic [REG_W-1:0] CLOCK_FIELD = 16'h00e0;
   localparam logic [REG_W-1:0] SYS_FIELD   = 16'h000f;
   localparam logic [REG_W-1:0] MASK_RESET  = 16'h0000;
   localparam logic [REG_W-1:0] STAT_RESET  = 16'h0000;

   // summary event bits
   localparam int unsigned      EVT_CLOCK_BIT = 0;
   localparam int unsigned      EVT_SYS_BIT   = 1;
   localparam logic [EVT_W-1:0] EVT_RESET     = 2'h0;

   typedef struct packed {
      logic periodicEventFlag;
      logic secondRolloverFlag;
      logic alarmFlag;
   } cirq_clock_src_type;

   typedef struct packed {
      logic supplyLowFlag;
      logic dieWarmFlag;
      logic dieHotFlag;
      logic watchdogExpiryFlag;
   } cirq_sys_src_type;

   localparam cirq_clock_src_type CLOCK_SRC_RESET = '{default: 1'b0};
   localparam cirq_sys_src_type   SYS_SRC_RESET   = '{default: 1'b0};

   function automatic logic [ADDR_W-1:0] cirq_byte_addr(input logic [ADDR_W-1:0] idx);
      return ADDR_W'(idx << IDX_SHIFT);
   endfunction

endpackage : cirq_pkg

// file: tb/cirq_clock_sys_irq_bench.sv
// self-checking bench of the clock and system interrupt groups
// assumes zero-wait apb slave and the source model beside the dut
module cirq_clock_sys_irq_bench
   import cirq_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   // ********************************************
   // signals
   // ********************************************
   localparam logic [7:0] ST1A = 8'h64;
   localparam logic [7:0] ST2A = 8'h68;
   localparam logic [7:0] MK1A = 8'h84;
   localparam logic [7:0] MK2A = 8'h88;
   localparam logic [7:0] SUMA = 8'h00;
   localparam logic [7:0] CLRA = 8'h04;
   localparam logic [7:0] ENA  = 8'h08;

   logic               core_clk;
   logic               reset;
   logic               psel;
   logic               penable;
   logic               pwrite;
   logic [ADDR_W-1:0]  paddr;
   logic [DATA_W-1:0]  pwdata;
   logic [DATA_W-1:0]  prdata;
   logic [DATA_W-1:0]  rdData;
   logic               pready;
   logic               pslverr;
   logic               rdErr;
   logic [6:0]         fire;
   cirq_clock_src_type clockSrc;
   cirq_sys_src_type   sysSrc;
   logic               clockGroupIrq;
   logic               systemGroupIrq;
   logic               irqOut;
   int                 miscompares;
   int                 nChecks;
   int                 cycles;

   cirq_clock_sys_irq dut (.core_clk(core_clk), .reset(reset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .clockSrc(clockSrc),
      .sysSrc(sysSrc), .clockGroupIrq(clockGroupIrq),
      .systemGroupIrq(systemGroupIrq), .irqOut(irqOut));

   cirq_src_model srcModel (.core_clk(core_clk), .reset(reset), .fire(fire),
      .clockSrc(clockSrc), .sysSrc(sysSrc));

   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   // ********************************************
   // shared tasks
   // ********************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      nChecks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // one transfer, then an idle cycle so no strobe is driven twice in one step
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      rdData  = prdata;
      rdErr   = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask

   // source k: 6..4 clock group bits 7..5, 3..0 system group bits 3..0
   task automatic pulse(input int k);
      fire[k] <= 1'b1;
      @(posedge core_clk);
      fire <= 7'h00;
      repeat (6) @(posedge core_clk);
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", nChecks, miscompares);
      if (miscompares == 0 && nChecks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // ********************************************
   // scenarios
   // ********************************************
   task automatic test_reset();
      apb(1'b0, MK1A, 32'h0);
      check(rdData, 32'h0);
      apb(1'b0, MK2A, 32'h0);
      check(rdData, 32'h0);
      check({clockGroupIrq, systemGroupIrq, irqOut}, 32'h0);
      $display("test reset done");
   endtask

   task automatic test_sources();
      logic [7:0]  a;
      logic [31:0] b;
      for (int k = 0; k < 7; k++) begin
         a = (k >= 4) ? ST1A : ST2A;
         b = 32'h1 << ((k >= 4) ? k + 1 : k);
         pulse(k);
         check((k >= 4) ? clockGroupIrq : systemGroupIrq, 1'b1);
         check((k >= 4) ? systemGroupIrq : clockGroupIrq, 1'b0);
         apb(1'b0, a, 32'h0);
         check(rdData, b);
         check({clockGroupIrq, systemGroupIrq}, 32'h0);
         apb(1'b0, a, 32'h0);
         check(rdData, 32'h0);
      end
      $display("test sources done");
   endtask

   task automatic test_mask();
      apb(1'b1, MK1A, 32'h80);
      apb(1'b1, MK2A, 32'h4);
      apb(1'b0, MK1A, 32'h0);
      check(rdData, 32'h80);
      apb(1'b0, MK2A, 32'h0);
      check(rdData, 32'h4);
      pulse(6);
      check(clockGroupIrq, 1'b0);
      pulse(5);
      check(clockGroupIrq, 1'b1);
      apb(1'b0, ST1A, 32'h0);
      check(rdData, 32'hc0);
      pulse(2);
      check(systemGroupIrq, 1'b0);
      pulse(1);
      check(systemGroupIrq, 1'b1);
      apb(1'b0, ST2A, 32'h0);
      check(rdData, 32'h6);
      apb(1'b1, MK1A, 32'he0);
      apb(1'b1, MK2A, 32'hf);
      pulse(4);
      check(clockGroupIrq, 1'b0);
      pulse(0);
      check(systemGroupIrq, 1'b0);
      apb(1'b0, ST1A, 32'h0);
      check(rdData, 32'h20);
      apb(1'b0, ST2A, 32'h0);
      check(rdData, 32'h1);
      apb(1'b1, MK1A, 32'h0);
      apb(1'b1, MK2A, 32'h0);
      $display("test mask done");
   endtask

   // summary level interrupt: raise, mask, clear
   task automatic test_summary();
      apb(1'b1, CLRA, 32'h3);
      apb(1'b1, ENA, 32'h1);
      check(irqOut, 1'b0);
      pulse(4);
      check(irqOut, 1'b1);
      apb(1'b0, SUMA, 32'h0);
      check(rdData, 32'h1);
      apb(1'b0, ST1A, 32'h0);
      check(rdData, 32'h20);
      apb(1'b1, CLRA, 32'h1);
      check(irqOut, 1'b0);
      pulse(3);
      check(irqOut, 1'b0);
      apb(1'b0, SUMA, 32'h0);
      check(rdData, 32'h2);
      apb(1'b0, ST2A, 32'h0);
      check(rdData, 32'h8);
      apb(1'b1, CLRA, 32'h2);
      apb(1'b0, SUMA, 32'h0);
      check(rdData, 32'h0);
      $display("test summary done");
   endtask

   // unmapped place and a write to a read-clear register
   task automatic test_unmapped();
      apb(1'b0, 8'h40, 32'h0);
      check(rdErr, 1'b1);
      check(rdData, 32'h0);
      apb(1'b1, ST1A, 32'hffff);
      apb(1'b0, ST1A, 32'h0);
      check(rdErr, 1'b0);
      check(rdData, 32'h0);
      $display("test unmapped done");
   endtask

   // ********************************************
   // main sequence and timeout
   // ********************************************
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         complete_run();
      end
   end

   initial begin
      reset = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      fire = 7'h00;
      miscompares = 0;
      nChecks = 0;
      cycles = 0;
      repeat (4) @(posedge core_clk);
      reset <= 1'b0;
      @(posedge core_clk);
      test_reset();
      test_sources();
      test_mask();
      test_summary();
      test_unmapped();
      complete_run();
   end
endmodule // cirq_clock_sys_irq_bench

// file: tb/cirq_src_model.sv
// event source model: turns one-cycle fire requests into source levels
// assumes fire is driven just after a rising edge of core_clk
module cirq_src_model
   import cirq_pkg::*;
(
   input  wire logic         core_clk,
   input  wire logic         reset,
   input  wire logic [6:0]   fire,
   output cirq_clock_src_type clockSrc,
   output cirq_sys_src_type   sysSrc
);
   timeunit 1ns;
   timeprecision 1ns;

   // ********************************************
   // level stretch
   // ********************************************
   logic [6:0] d1_ff;
   logic [6:0] d2_ff;
   logic [6:0] d3_ff;
   logic [6:0] level;

   // source raised only on request, held four cycles
   // so the synchroniser sees a clean rising edge
   always_ff @(posedge core_clk) begin
      if (reset) begin
         d1_ff <= 7'h00;
         d2_ff <= 7'h00;
         d3_ff <= 7'h00;
      end else begin
         d1_ff <= fire;
         d2_ff <= d1_ff;
         d3_ff <= d2_ff;
      end
   end

   assign level    = fire | d1_ff | d2_ff | d3_ff;
   assign clockSrc = level[6:4];
   assign sysSrc   = level[3:0];
endmodule // cirq_src_model
